/* design/gpio_datapath_ctrl_regs.sv */
// aux pin configuration, data-path control and strap status behind axi4-lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module gpio_datapath_ctrl_regs import bridge_regs_pkg::*; #(
   parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic aux_pin_seven_in,
   output logic aux_pin_seven_out,
   output logic aux_pin_seven_oe,
   input wire logic aux_pin_eight_in,
   output logic aux_pin_eight_out,
   output logic aux_pin_eight_oe,
   output logic [1:0] aux_pin_func_in,
   output logic [1:0] aux_pin_gp_level,
   input wire logic [STRAP_W-1:0] strap_level_pin_a,
   input wire logic [STRAP_W-1:0] strap_level_pin_b,
   input wire logic pixel_de,
   input wire logic [23:0] pixel_rgb,
   output logic pixel_out_valid,
   output logic [23:0] pixel_out_rgb,
   output logic raw_pixel_passthrough,
   output logic content_protect_disable,
   output logic packet_audio_block,
   output logic de_active_low,
   output logic video_18bit,
   input wire logic i2s_video_data,
   input wire logic i2s_pin_data,
   output logic i2s_audio_data,
   output logic i2s_regen_sel,
   output logic i2s_island_carry,
   output logic i2s_frame_carry,
   input wire logic inband_mode_valid,
   input wire logic inband_chan_b_en,
   output logic i2s_chan_b_enable
);
   typedef struct packed {
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [7:0] aux_pins;
      logic [7:0] data_path;
      logic [7:0] strap_status;
      logic [1:0] pin_sync1;
      logic [1:0] pin_sync2;
      logic pix_valid;
      logic [23:0] pix_rgb;
      logic audio_data;
      logic chan_b_en;
   } ctrl_st_t;

   ctrl_st_t st_reg;
   ctrl_st_t st_next;

   logic [STRAP_W-1:0] strap_a_level;
   logic strap_a_done;
   logic [STRAP_W-1:0] strap_b_level;
   logic strap_b_done;
   logic [1:0] pin_in;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic de_active;
   logic forward_pixel;

   function automatic pin_mode_t pin_mode_of(input logic [7:0] cfg, input int lsb);
      pin_mode_t m;
      m = pin_mode_t'(cfg[lsb +: 2]);
      return m;
   endfunction

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
      logic hit;
      hit = (addr[ADDR_W-1:2] == idx);
      return hit;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      logic m;
      m = reg_hit(addr, IDX_AUX_PINS) || reg_hit(addr, IDX_DATA_PATH) || reg_hit(addr, IDX_STRAP_STATUS);
      return m;
   endfunction

   strap_latch #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_strap_a (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .level_in(strap_level_pin_a),
      .level_out(strap_a_level),
      .done(strap_a_done)
   );

   strap_latch #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_strap_b (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .level_in(strap_level_pin_b),
      .level_out(strap_b_level),
      .done(strap_b_done)
   );

   // one write and one read in flight; a new address waits for the response
   assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
   assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
   assign s_axi_arready = !st_reg.rvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   assign de_active = pixel_de ^ st_reg.data_path[DE_POL_BIT];
   assign forward_pixel = de_active || st_reg.data_path[RAW_PASS_BIT];

   always_comb begin
      st_next = st_reg;
      st_next.pin_sync1 = pin_in;
      st_next.pin_sync2 = st_reg.pin_sync1;

      if (aw_take) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end

      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         // only byte lane 0 carries register bits
         if (st_reg.w_strb[0]) begin
            if (reg_hit(st_reg.aw_addr, IDX_AUX_PINS)) begin
               st_next.aux_pins = st_reg.w_data[7:0] & AUX_PINS_RW_MASK;
            end
            if (reg_hit(st_reg.aw_addr, IDX_DATA_PATH)) begin
               st_next.data_path = st_reg.w_data[7:0] & DATA_PATH_RW_MASK;
            end
         end
         // the status word accepts a write with okay and keeps its value
      end else if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      if (ar_take) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         st_next.rdata = '0;
         if (reg_hit(s_axi_araddr, IDX_AUX_PINS)) begin
            st_next.rdata = {24'h000000, st_reg.aux_pins};
         end
         if (reg_hit(s_axi_araddr, IDX_DATA_PATH)) begin
            st_next.rdata = {24'h000000, st_reg.data_path};
         end
         if (reg_hit(s_axi_araddr, IDX_STRAP_STATUS)) begin
            st_next.rdata = {24'h000000, st_reg.strap_status};
         end
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      st_next.strap_status = '0;
      st_next.strap_status[STRAP_B_DONE_BIT] = strap_b_done;
      st_next.strap_status[STRAP_B_LSB +: STRAP_W] = strap_b_level;
      st_next.strap_status[STRAP_A_DONE_BIT] = strap_a_done;
      st_next.strap_status[STRAP_A_LSB +: STRAP_W] = strap_a_level;

      st_next.pix_valid = forward_pixel;
      if (!forward_pixel) begin
         st_next.pix_rgb = '0;
      end else if (st_reg.data_path[VID18_BIT]) begin
         st_next.pix_rgb = pixel_rgb & RGB18_MASK;
      end else begin
         st_next.pix_rgb = pixel_rgb;
      end

      // regenerate from the dedicated pins, otherwise pass what came with video
      st_next.audio_data = st_reg.data_path[REGEN_BIT] ? i2s_pin_data : i2s_video_data;

      if (st_reg.data_path[CHB_OVR_BIT]) begin
         st_next.chan_b_en = st_reg.data_path[CHB_EN_BIT];
      end else if (inband_mode_valid) begin
         st_next.chan_b_en = inband_chan_b_en;
      end else begin
         st_next.chan_b_en = st_reg.data_path[CHB_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.aux_pins <= AUX_PINS_RESET;
         st_reg.data_path <= DATA_PATH_RESET;
         st_reg.strap_status <= STRAP_STATUS_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_in = {aux_pin_eight_in, aux_pin_seven_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         localparam int MODE_LSB = (gi == 0) ? PIN7_MODE_LSB : PIN8_MODE_LSB;
         localparam int VALUE_BIT = (gi == 0) ? PIN7_VALUE_BIT : PIN8_VALUE_BIT;
         pin_mode_t mode;
         assign mode = pin_mode_of(st_reg.aux_pins, MODE_LSB);
         assign pin_oe[gi] = (mode == PIN_GP_OUT);
         assign pin_out[gi] = (mode == PIN_GP_OUT) ? st_reg.aux_pins[VALUE_BIT] : 1'b0;
         assign aux_pin_func_in[gi] = (mode == PIN_FUNC) ? st_reg.pin_sync2[gi] : 1'b0;
         assign aux_pin_gp_level[gi] = (mode == PIN_GP_IN) ? st_reg.pin_sync2[gi] : 1'b0;
      end
   endgenerate

   assign aux_pin_seven_out = pin_out[0];
   assign aux_pin_seven_oe = pin_oe[0];
   assign aux_pin_eight_out = pin_out[1];
   assign aux_pin_eight_oe = pin_oe[1];

   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;

   assign pixel_out_valid = st_reg.pix_valid;
   assign pixel_out_rgb = st_reg.pix_rgb;
   assign raw_pixel_passthrough = st_reg.data_path[RAW_PASS_BIT];
   // protection and packet audio cannot follow pixels sent without de framing
   assign content_protect_disable = st_reg.data_path[RAW_PASS_BIT];
   assign packet_audio_block = st_reg.data_path[RAW_PASS_BIT];
   assign de_active_low = st_reg.data_path[DE_POL_BIT];
   assign video_18bit = st_reg.data_path[VID18_BIT];

   assign i2s_audio_data = st_reg.audio_data;
   assign i2s_regen_sel = st_reg.data_path[REGEN_BIT];
   assign i2s_island_carry = !st_reg.data_path[TRANSPORT_BIT] && !st_reg.data_path[RAW_PASS_BIT];
   assign i2s_frame_carry = st_reg.data_path[TRANSPORT_BIT];
   assign i2s_chan_b_enable = st_reg.chan_b_en;
endmodule // gpio_datapath_ctrl_regs

/* design/strap_latch.sv */
// multi-level strap sampler: waits for a steady decode, then latches it once
`timescale 1ns/10ps
module strap_latch import bridge_regs_pkg::*; #(
   parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [STRAP_W-1:0] level_in,
   output logic [STRAP_W-1:0] level_out,
   output logic done
);
   typedef struct packed {
      logic [STRAP_W-1:0] sync1;
      logic [STRAP_W-1:0] sync2;
      logic [STRAP_W-1:0] prev;
      logic [SETTLE_CNT_W-1:0] cnt;
      logic [STRAP_W-1:0] level;
      logic done;
   } strap_st_t;

   strap_st_t st_reg;
   strap_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.sync1 = level_in;
      st_next.sync2 = st_reg.sync1;
      st_next.prev = st_reg.sync2;
      // latched once: a strap is a power-up choice, later wiggles are ignored
      if (!st_reg.done) begin
         if (st_reg.sync2 != st_reg.prev) begin
            st_next.cnt = '0;
         end else if (st_reg.cnt == SETTLE_CNT_W'(SETTLE_CYCLES - 1)) begin
            st_next.level = st_reg.sync2;
            st_next.done = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.level;
   assign done = st_reg.done;
endmodule // strap_latch

/* shared/bridge_regs_pkg.sv */
// constants and types for the pin, data-path and strap status register slice
// Functional notes
// - gp output pins drive their value bit
// - two-bit mode: func, gp-out, hi-z, gp-in
// - raw passthrough ignores de, blocks protection, audio
// - polarity bit selects de active high or low
// - regen bit picks i2s pins over video
// - override forces channel b enable from bit0
// - width bit: 0 is 24-bit, 1 18-bit
// - transport bit: island packets or frame carriage
// - bit0 enables channel b, in-band may override
// - strap b done flag and level reported
// - strap a done flag and level reported
package bridge_regs_pkg;
   localparam int ADDR_W = 8;
   localparam int IDX_W = 6;
   localparam int DATA_W = 32;
   localparam logic [IDX_W-1:0] IDX_AUX_PINS = 6'h11;
   localparam logic [IDX_W-1:0] IDX_DATA_PATH = 6'h12;
   localparam logic [IDX_W-1:0] IDX_STRAP_STATUS = 6'h13;
   localparam logic [7:0] AUX_PINS_RESET = 8'h00;
   localparam logic [7:0] DATA_PATH_RESET = 8'h00;
   localparam logic [7:0] STRAP_STATUS_RESET = 8'h88;
   localparam logic [7:0] AUX_PINS_RW_MASK = 8'hBB;
   localparam logic [7:0] DATA_PATH_RW_MASK = 8'h7F;
   localparam int PIN7_VALUE_BIT = 3;
   localparam int PIN7_MODE_LSB = 0;
   localparam int PIN8_VALUE_BIT = 7;
   localparam int PIN8_MODE_LSB = 4;
   localparam int RAW_PASS_BIT = 6;
   localparam int DE_POL_BIT = 5;
   localparam int REGEN_BIT = 4;
   localparam int CHB_OVR_BIT = 3;
   localparam int VID18_BIT = 2;
   localparam int TRANSPORT_BIT = 1;
   localparam int CHB_EN_BIT = 0;
   localparam int STRAP_B_DONE_BIT = 7;
   localparam int STRAP_B_LSB = 4;
   localparam int STRAP_A_DONE_BIT = 3;
   localparam int STRAP_A_LSB = 0;
   localparam int STRAP_W = 3;
   localparam logic [23:0] RGB18_MASK = 24'hFCFCFC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PERIOD_NS = 25;
   localparam int STRAP_SETTLE_NS = 10000;
   localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CNT_W = 16;
   typedef enum logic [1:0] {
      PIN_FUNC = 2'h0,
      PIN_GP_OUT = 2'h1,
      PIN_HIZ = 2'h2,
      PIN_GP_IN = 2'h3
   } pin_mode_t;
endpackage

/* tb/gpio_datapath_ctrl_regs_monitor.sv */
// concurrent checks on the register slice ports
`timescale 1ns/10ps
module gpio_datapath_ctrl_regs_monitor import bridge_regs_pkg::*; #(
   parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic aux_pin_seven_out,
   input wire logic aux_pin_seven_oe,
   input wire logic aux_pin_eight_out,
   input wire logic aux_pin_eight_oe,
   input wire logic [1:0] aux_pin_func_in,
   input wire logic [1:0] aux_pin_gp_level,
   input wire logic pixel_de,
   input wire logic [23:0] pixel_rgb,
   input wire logic pixel_out_valid,
   input wire logic [23:0] pixel_out_rgb,
   input wire logic raw_pixel_passthrough,
   input wire logic content_protect_disable,
   input wire logic packet_audio_block,
   input wire logic de_active_low,
   input wire logic video_18bit,
   input wire logic i2s_video_data,
   input wire logic i2s_pin_data,
   input wire logic i2s_audio_data,
   input wire logic i2s_regen_sel,
   input wire logic i2s_island_carry,
   input wire logic i2s_frame_carry
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_pin_seven_drive: assert property (aux_pin_seven_out |-> aux_pin_seven_oe)
      else $error("pin seven driven high while not enabled");
   chk_pin_eight_drive: assert property (aux_pin_eight_out |-> aux_pin_eight_oe)
      else $error("pin eight driven high while not enabled");
   chk_pin_mode_excl: assert property (aux_pin_seven_oe |-> !aux_pin_func_in[0] && !aux_pin_gp_level[0])
      else $error("output pin also routed as input");
   chk_raw_side_effects: assert property (raw_pixel_passthrough == content_protect_disable
      && raw_pixel_passthrough == packet_audio_block)
      else $error("raw passthrough side effects mismatch");
   chk_de_forward: assert property ($past(rst_n) |-> pixel_out_valid ==
      ($past(raw_pixel_passthrough) || ($past(pixel_de) ^ $past(de_active_low))))
      else $error("pixel forward does not follow enable polarity");
   chk_rgb_width: assert property ($past(rst_n) && pixel_out_valid |-> pixel_out_rgb ==
      ($past(pixel_rgb) & ($past(video_18bit) ? RGB18_MASK : 24'hFFFFFF)))
      else $error("pixel width mask wrong");
   chk_i2s_source: assert property ($past(rst_n) |-> i2s_audio_data ==
      ($past(i2s_regen_sel) ? $past(i2s_pin_data) : $past(i2s_video_data)))
      else $error("audio source wrong");
   chk_transport_excl: assert property (!(i2s_island_carry && i2s_frame_carry))
      else $error("both audio transports active");
   chk_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
endmodule // gpio_datapath_ctrl_regs_monitor

bind gpio_datapath_ctrl_regs gpio_datapath_ctrl_regs_monitor #(
   .SETTLE_CYCLES(SETTLE_CYCLES)
) mon (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .aux_pin_seven_out(aux_pin_seven_out),
   .aux_pin_seven_oe(aux_pin_seven_oe),
   .aux_pin_eight_out(aux_pin_eight_out),
   .aux_pin_eight_oe(aux_pin_eight_oe),
   .aux_pin_func_in(aux_pin_func_in),
   .aux_pin_gp_level(aux_pin_gp_level),
   .pixel_de(pixel_de),
   .pixel_rgb(pixel_rgb),
   .pixel_out_valid(pixel_out_valid),
   .pixel_out_rgb(pixel_out_rgb),
   .raw_pixel_passthrough(raw_pixel_passthrough),
   .content_protect_disable(content_protect_disable),
   .packet_audio_block(packet_audio_block),
   .de_active_low(de_active_low),
   .video_18bit(video_18bit),
   .i2s_video_data(i2s_video_data),
   .i2s_pin_data(i2s_pin_data),
   .i2s_audio_data(i2s_audio_data),
   .i2s_regen_sel(i2s_regen_sel),
   .i2s_island_carry(i2s_island_carry),
   .i2s_frame_carry(i2s_frame_carry)
);

/* tb/tb.sv */
// self-checking bench for the register slice
`timescale 1ns/10ps
module tb import bridge_regs_pkg::*;;
   logic sys_clk = 1'b0, rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] strb = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, m;
   logic p7_in = 1, p8_in = 1, p7_out, p7_oe, p8_out, p8_oe, de = 1, pvalid, raw, cpd, pab, del, v18;
   logic [1:0] func_in, gp_level;
   logic [2:0] sa = 3'h5, sb = 3'h3;
   logic [23:0] rgb = 24'h123456, orgb;
   logic iv = 0, ip = 1, ia, regen, island, frame, ibv = 1, ibe = 0, chb;
   int fails = 0, samples_checked = 0, cyc = 0;
   always #12.5 sys_clk = ~sys_clk;
   gpio_datapath_ctrl_regs #(.SETTLE_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_pin_seven_in(p7_in),
      .aux_pin_seven_out(p7_out), .aux_pin_seven_oe(p7_oe), .aux_pin_eight_in(p8_in),
      .aux_pin_eight_out(p8_out), .aux_pin_eight_oe(p8_oe), .aux_pin_func_in(func_in),
      .aux_pin_gp_level(gp_level), .strap_level_pin_a(sa), .strap_level_pin_b(sb), .pixel_de(de),
      .pixel_rgb(rgb), .pixel_out_valid(pvalid), .pixel_out_rgb(orgb), .raw_pixel_passthrough(raw),
      .content_protect_disable(cpd), .packet_audio_block(pab), .de_active_low(del), .video_18bit(v18),
      .i2s_video_data(iv), .i2s_pin_data(ip), .i2s_audio_data(ia), .i2s_regen_sel(regen),
      .i2s_island_carry(island), .i2s_frame_carry(frame), .inband_mode_valid(ibv),
      .inband_chan_b_en(ibe), .i2s_chan_b_enable(chb));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (!aw_ok && awready) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok));
      do @(posedge sys_clk); while (!bvalid);
      bready <= 1'b0;
      check("write response", {30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rvalid);
      rready <= 1'b0;
      check("read data", rdata, {24'h000000, exp});
      check("read response", {30'h0, rresp}, {30'h0, er});
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_reg(8'h44, 8'h00, RESP_OKAY);
      rd_reg(8'h48, 8'h00, RESP_OKAY);
      repeat (20) @(posedge sys_clk);
      rd_reg(8'h4C, 8'hBD, RESP_OKAY);
      sa <= 3'h2;
      wr(8'h4C, 8'h00, RESP_OKAY);
      repeat (12) @(posedge sys_clk);
      rd_reg(8'h4C, 8'hBD, RESP_OKAY);
      wr(8'h50, 8'hFF, RESP_SLVERR);
      rd_reg(8'h50, 8'h00, RESP_SLVERR);
      $display("test status and map done");
      // every mode on both pins, value bit high so a wrong drive shows
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         wr(8'h44, {2'b10, m, 2'b10, m}, RESP_OKAY);
         repeat (3) @(posedge sys_clk);
         check("pin drive", {p8_oe, p8_out, p7_oe, p7_out}, {4{m == PIN_GP_OUT}});
         check("pin func in", {30'h0, func_in}, {30'h0, {2{m == PIN_FUNC}}});
         check("pin gp level", {30'h0, gp_level}, {30'h0, {2{m == PIN_GP_IN}}});
      end
      wr(8'h44, 8'h11, RESP_OKAY);
      check("pin low drive", {p8_oe, p8_out, p7_oe, p7_out}, 32'hA);
      wr(8'h44, 8'hFF, RESP_OKAY);
      rd_reg(8'h44, 8'hBB, RESP_OKAY);
      $display("test aux pins done");
      wr(8'h48, 8'hFF, RESP_OKAY);
      rd_reg(8'h48, 8'h7F, RESP_OKAY);
      check("path all set", {raw, cpd, pab, del, v18, regen, frame, island}, 32'hFE);
      wr(8'h48, 8'h00, RESP_OKAY);
      check("path all clear", {raw, cpd, pab, del, v18, regen, frame, island}, 32'h01);
      wr(8'h48, 8'h20, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("inverted enable", {pvalid, orgb}, 32'h0);
      wr(8'h48, 8'h60, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("raw forward", {pvalid, orgb}, 32'h1123456);
      wr(8'h48, 8'h14, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("narrow video", {pvalid, orgb}, 32'h1103454);
      check("regen audio", {31'h0, ia}, 32'h1);
      // idle enable level with normal polarity must stop forwarding
      de <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("idle enable", {pvalid, orgb}, 32'h0);
      // low byte lane not strobed: the write is answered but changes nothing
      strb <= 4'hE;
      wr(8'h48, 8'h00, RESP_OKAY);
      strb <= 4'hF;
      rd_reg(8'h48, 8'h14, RESP_OKAY);
      $display("test data path done");
      wr(8'h48, 8'h09, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("override on", {31'h0, chb}, 32'h1);
      wr(8'h48, 8'h08, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("override off", {31'h0, chb}, 32'h0);
      wr(8'h48, 8'h01, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      check("inband wins", {31'h0, chb}, 32'h0);
      ibv <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check("enable bit", {31'h0, chb}, 32'h1);
      $display("test channel b done");
      stop_test();
   end
endmodule // tb
